// >>> rtl/bus_controller.sv
// Two-wire bus controller driven by software over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "serial_mem_consts.svh"
module bus_controller
    import serial_mem_pkg::*;
#(
    parameter int QUARTER = `SCL_PERIOD_NS / 4 / `CLK_PERIOD_NS
) (
    input wire logic clk,                   // System clock, 100 MHz.
    input wire logic nrst,                  // Asynchronous reset, active low.
    serial_link_if.controller link,         // Two-wire link.
    input wire logic [3:0] avs_address,     // Byte address.
    input wire logic avs_read,              // Read request.
    input wire logic avs_write,             // Write request.
    input wire logic [31:0] avs_writedata,  // Write data.
    output logic [31:0] avs_readdata,       // Read data.
    output logic avs_waitrequest            // Stall.
);
    logic sda_s;
    logic tick;
    logic accept;
    host_op_t op;

    host_state_t state_q, state_d;
    logic [15:0] qcnt_q, qcnt_d;
    logic [1:0] qi_q, qi_d;
    logic [3:0] bi_q, bi_d;
    logic [7:0] tx_q, tx_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    logic acked_q, acked_d;
    logic bus_ok_q, bus_ok_d;
    logic rd_done_q, rd_done_d;
    logic [31:0] rdata_q, rdata_d;

    // Only the data wire is read back; the clock is never stretched by the target.
    sync2 #(.W(1), .INIT(1'h1)) u_link_sync (
        .clk(clk),
        .nrst(nrst),
        .d(link.sda),
        .q(sda_s)
    );

    assign tick = (qcnt_q == 16'(QUARTER - 1));
    assign op = host_op_t'(avs_writedata[`CMD_OP_LSB +: 2]);
    assign accept = avs_write && (avs_address == `CMD_OFFSET) && (state_q == H_IDLE);
    // Commands stall while one is running; reads take one wait cycle.
    assign avs_waitrequest = (avs_write && (avs_address == `CMD_OFFSET) && (state_q != H_IDLE))
                           || (avs_read && !rd_done_q);

    // Next values of the bit engine and the register slave.
    always_comb begin
        state_d = state_q;
        qcnt_d = qcnt_q;
        qi_d = qi_q;
        bi_d = bi_q;
        tx_d = tx_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        acked_d = acked_q;
        bus_ok_d = bus_ok_q;
        rd_done_d = avs_read && !rd_done_q;
        rdata_d = 32'h00000000;
        if (avs_address == `STATUS_OFFSET) begin
            rdata_d[`STAT_BUSY_BIT] = (state_q != H_IDLE);
            rdata_d[`STAT_ACK_BIT] = acked_q;
            rdata_d[`STAT_BUS_OK_BIT] = bus_ok_q;
        end
        if (accept) begin
            qcnt_d = 16'h0000;
            qi_d = 2'h0;
            bi_d = 4'h0;
            tx_d = avs_writedata[`CMD_DATA_LSB +: 8];
            case (op)
                OP_START: state_d = H_START;
                OP_STOP: state_d = H_STOP;
                OP_BYTE: state_d = H_BYTE;
                default: state_d = H_RECOV;
            endcase
        end else if (state_q != H_IDLE) begin
            qcnt_d = tick ? 16'h0000 : qcnt_q + 16'h0001;
            if (tick) begin
                qi_d = qi_q + 2'h1;
                case (state_q)
                    H_START: begin
                        // Release data, raise clock, then pull data low.
                        case (qi_q)
                            2'h0: sda_low_d = 1'b0;
                            2'h1: scl_low_d = 1'b0;
                            2'h2: sda_low_d = 1'b1;
                            default: begin
                                scl_low_d = 1'b1;
                                state_d = H_IDLE;
                            end
                        endcase
                    end
                    H_STOP: begin
                        case (qi_q)
                            2'h0: begin
                                scl_low_d = 1'b1;
                                sda_low_d = 1'b1;
                            end
                            2'h1: scl_low_d = 1'b0;
                            2'h2: sda_low_d = 1'b0;
                            default: state_d = H_IDLE;
                        endcase
                    end
                    H_BYTE: begin
                        case (qi_q)
                            // Data changes only in the clock-low quarter.
                            2'h0: sda_low_d = (bi_q < `WORD_BITS) ? ~tx_q[7] : 1'b0;
                            2'h1: scl_low_d = 1'b0;
                            2'h2: begin
                                if (bi_q == `WORD_BITS) begin
                                    acked_d = ~sda_s;
                                end
                            end
                            default: begin
                                scl_low_d = 1'b1;
                                tx_d = {tx_q[6:0], 1'b0};
                                bi_d = bi_q + 4'h1;
                                if (bi_q == `WORD_BITS) begin
                                    state_d = H_IDLE;
                                end
                            end
                        endcase
                    end
                    default: begin
                        case (qi_q)
                            2'h0: begin
                                sda_low_d = 1'b0;
                                scl_low_d = 1'b1;
                            end
                            2'h1: scl_low_d = 1'b0;
                            2'h2: begin
                                if (sda_s) begin
                                    bus_ok_d = 1'b1;
                                    state_d = H_START;
                                    qi_d = 2'h0;
                                end
                            end
                            default: begin
                                scl_low_d = 1'b1;
                                bi_d = bi_q + 4'h1;
                                if (bi_q == `RECOVER_LAST) begin
                                    bus_ok_d = 1'b0;
                                    state_d = H_IDLE;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // Registers of the bit engine and the register slave.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= H_IDLE;
            qcnt_q <= 16'h0000;
            qi_q <= 2'h0;
            bi_q <= 4'h0;
            tx_q <= 8'h00;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            acked_q <= 1'b0;
            bus_ok_q <= 1'b0;
            rd_done_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            qcnt_q <= qcnt_d;
            qi_q <= qi_d;
            bi_q <= bi_d;
            tx_q <= tx_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            acked_q <= acked_d;
            bus_ok_q <= bus_ok_d;
            rd_done_q <= rd_done_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign link.scl_o = 1'b0;
    assign link.scl_oe = scl_low_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_low_q;
endmodule
`default_nettype wire

// >>> rtl/eeprom_target.sv
// Two-wire memory target: address decode, byte and page writes, timed write cycle.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "serial_mem_consts.svh"
module eeprom_target
    import serial_mem_pkg::*;
#(
    parameter bit VARIANT_4K = 1'b0,
    parameter int WRITE_CYCLES = `INTERNAL_WRITE_TIME_MS * `CLK_FREQ_KHZ
) (
    input wire logic clk,                     // System clock, 100 MHz.
    input wire logic nrst,                    // Asynchronous reset, active low.
    serial_link_if.target link,               // Two-wire link.
    input wire logic chip_select_pin_upper,   // Hardwired select pin, top.
    input wire logic chip_select_pin_middle,  // Hardwired select pin, middle.
    input wire logic chip_select_pin_lowest,  // Hardwired select pin, unused in large variant.
    input wire logic [8:0] peek_addr,         // Array inspection address.
    output logic [7:0] peek_data,             // Array word at peek_addr, one cycle later.
    output logic write_busy,                  // High during the internal write cycle.
    output logic standby                      // High while idle and not writing.
);
    localparam logic [8:0] PMASK = VARIANT_4K ? `PAGE_MASK_4K : `PAGE_MASK_2K;

    logic scl_s;
    logic sda_s;
    logic [2:0] cs_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic addr_match;
    logic commit;

    dev_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic ack_ph_q, ack_ph_d;
    logic ack_low_q, ack_low_d;
    logic [7:0] shift_q, shift_d;
    logic [8:0] addr_q, addr_d;
    logic [7:0] buf_q [0:`PAGE_MAX-1];
    logic [7:0] buf_d [0:`PAGE_MAX-1];
    logic [`PAGE_MAX-1:0] vld_q, vld_d;
    logic busy_q, busy_d;
    logic [31:0] tmr_q, tmr_d;
    logic standby_q, standby_d;
    logic [7:0] mem_q [0:`MEM_WORDS-1];
    logic [7:0] peek_q;

    // The link and the select straps come from outside the clock domain.
    sync2 #(.W(2), .INIT(2'h3)) u_link_sync (
        .clk(clk),
        .nrst(nrst),
        .d({link.scl, link.sda}),
        .q({scl_s, sda_s})
    );

    sync2 #(.W(3), .INIT(3'h0)) u_cs_sync (
        .clk(clk),
        .nrst(nrst),
        .d({chip_select_pin_upper, chip_select_pin_middle, chip_select_pin_lowest}),
        .q(cs_s)
    );

    // Edge and condition detection on the synchronised link.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    // A data edge while the clock stays high is never data.
    assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Fixed prefix, then the select pins; the large variant skips the lowest pin.
    assign addr_match = (shift_q[7:4] == `DEV_PREFIX)
                      && (shift_q[3] == cs_s[2]) && (shift_q[2] == cs_s[1])
                      && (VARIANT_4K || (shift_q[1] == cs_s[0]));

    // The buffered page goes to the array on the last cycle of the write timer.
    assign commit = busy_q && (tmr_q == 32'(WRITE_CYCLES - 1));

    // Next-state logic of the protocol engine and the write timer.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ack_ph_d = ack_ph_q;
        ack_low_d = ack_low_q;
        shift_d = shift_q;
        addr_d = addr_q;
        buf_d = buf_q;
        vld_d = vld_q;
        busy_d = busy_q;
        tmr_d = tmr_q;
        if (busy_q) begin
            tmr_d = tmr_q + 32'h00000001;
            if (commit) begin
                busy_d = 1'b0;
                vld_d = '0;
            end
        end
        if (start_c) begin
            // A start aborts any transfer in progress, repeated starts included; the write timer runs on.
            state_d = ST_DEV;
            cnt_d = 4'h0;
            ack_ph_d = 1'b0;
            ack_low_d = 1'b0;
        end else if (stop_c) begin
            ack_low_d = 1'b0;
            ack_ph_d = 1'b0;
            state_d = ST_IDLE;
            if (state_q == ST_DATA && |vld_q && !busy_q) begin
                busy_d = 1'b1;
                tmr_d = 32'h00000000;
            end
        end else if (state_q != ST_IDLE) begin
            if (scl_rise && !ack_ph_q && cnt_q < `WORD_BITS) begin
                shift_d = {shift_q[6:0], sda_s};
                cnt_d = cnt_q + 4'h1;
            end else if (scl_fall && ack_ph_q) begin
                // End of the ninth clock: let go of the data line.
                ack_low_d = 1'b0;
                ack_ph_d = 1'b0;
                cnt_d = 4'h0;
            end else if (scl_fall && cnt_q == `WORD_BITS) begin
                ack_ph_d = 1'b1;
                case (state_q)
                    ST_DEV: begin
                        // A polling start during the write cycle gets no answer.
                        if (addr_match && !busy_q) begin
                            ack_low_d = 1'b1;
                            state_d = shift_q[0] ? ST_READ : ST_ADDR;
                            vld_d = '0;
                            if (VARIANT_4K) begin
                                addr_d[8] = shift_q[1];
                            end
                        end else begin
                            ack_low_d = 1'b0;
                            state_d = ST_IDLE;
                        end
                    end
                    ST_ADDR: begin
                        addr_d[7:0] = shift_q;
                        ack_low_d = 1'b1;
                        state_d = ST_DATA;
                    end
                    ST_DATA: begin
                        // Bytes past the page end overwrite the earliest ones.
                        buf_d[addr_q[3:0] & PMASK[3:0]] = shift_q;
                        vld_d[addr_q[3:0] & PMASK[3:0]] = 1'b1;
                        addr_d = (addr_q & ~PMASK) | ((addr_q + 9'h001) & PMASK);
                        ack_low_d = 1'b1;
                    end
                    default: begin
                        // Read data output is not provided; the line stays released.
                        ack_low_d = 1'b0;
                    end
                endcase
            end
        end
        standby_d = (state_d == ST_IDLE) && !busy_d;
    end

    // Registers of the protocol engine; standby is the power-up state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            ack_ph_q <= 1'b0;
            ack_low_q <= 1'b0;
            shift_q <= 8'h00;
            addr_q <= 9'h000;
            buf_q <= '{default: 8'h00};
            vld_q <= '0;
            busy_q <= 1'b0;
            tmr_q <= 32'h00000000;
            standby_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ack_ph_q <= ack_ph_d;
            ack_low_q <= ack_low_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            buf_q <= buf_d;
            vld_q <= vld_d;
            busy_q <= busy_d;
            tmr_q <= tmr_d;
            standby_q <= standby_d;
        end
    end

    // Nonvolatile array: only bytes received in the page are written.
    always_ff @(posedge clk) begin
        if (commit) begin
            for (int i = 0; i < `PAGE_MAX; i++) begin
                if (vld_q[i]) begin
                    mem_q[(addr_q & ~PMASK) | 9'(i)] <= buf_q[i];
                end
            end
        end
        peek_q <= mem_q[peek_addr];
    end

    assign peek_data = peek_q;
    assign write_busy = busy_q;
    assign standby = standby_q;
    // Open-drain data: the output value is always low, the enable pulls.
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = ack_low_q;
endmodule
`default_nettype wire

// >>> rtl/serial_link_if.sv
// Two-wire link between the bus controller and the memory target.
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
    logic scl_o;
    logic scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: any enabled low driver pulls the line low.
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport controller (output scl_o, output scl_oe, output host_sda_o, output host_sda_oe,
                        input scl, input sda);
    modport target (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// >>> rtl/serial_mem_consts.svh
// Named constants shared by the two-wire memory target and its bus controller.
// Functional notes
// - Data changes only while clock is low.
// - Rising data with clock high is stop.
// - Target acknowledges each byte on ninth clock.
// - Target idles in standby after power-up, stop.
// - Recovery: nine pulses, look for high data.
// - Start followed by address word, prefix 1010.
// - Small variant compares all three select pins.
// - Large variant compares two pins, page bit.
// - Address word bit zero selects read or write.
// - Match acknowledges; mismatch returns to standby silently.
// - Byte write: word address, one byte, stop.
// - Self-timed write cycle ignores the bus.
// - Write cycle lasts five milliseconds after stop.
// - Page write accepts up to page size bytes.
// - Low address bits wrap inside the page.
// - Acknowledge polling answers only after write cycle.
// - Small variant 8-bit address, large 9-bit.
`ifndef SERIAL_MEM_CONSTS_SVH
`define SERIAL_MEM_CONSTS_SVH

`define DEV_PREFIX 4'hA
`define WORD_BITS 4'h8
`define RECOVER_LAST 4'h8
`define MEM_WORDS 512
`define PAGE_MAX 16
`define PAGE_MASK_2K 9'h007
`define PAGE_MASK_4K 9'h00F
`define INTERNAL_WRITE_TIME_MS 5
`define CLK_FREQ_KHZ 100000
`define CLK_PERIOD_NS 10
`define SCL_PERIOD_NS 2500
`define CMD_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define CMD_DATA_LSB 0
`define CMD_OP_LSB 8
`define STAT_BUSY_BIT 0
`define STAT_ACK_BIT 1
`define STAT_BUS_OK_BIT 2

`endif

// >>> rtl/serial_mem_pkg.sv
// Types shared by the two-wire memory target and its bus controller.
package serial_mem_pkg;

    typedef enum logic [1:0] {
        OP_START,
        OP_STOP,
        OP_BYTE,
        OP_RECOVER
    } host_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR,
        ST_DATA,
        ST_READ
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_STOP,
        H_BYTE,
        H_RECOV
    } host_state_t;

endpackage

// >>> rtl/sync2.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,          // System clock.
    input wire logic nrst,         // Asynchronous reset, active low.
    input wire logic [W-1:0] d,    // Asynchronous input.
    output logic [W-1:0] q         // Synchronised output.
);
    logic [W-1:0] meta_q;

    // Only the second flop is visible to the rest of the design.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> tb/serial_link_checker.sv
// Assertions on the two-wire link and the memory target's write-cycle flags.
`timescale 1ns/1ps
`default_nettype none
module serial_link_checker #(
    parameter int QUARTER = 10,
    parameter int WRITE_CYCLES = 1000
) (
    input wire logic clk,        // System clock.
    input wire logic nrst,       // Reset, active low.
    input wire logic scl,        // Resolved clock wire.
    input wire logic sda,        // Resolved data wire.
    input wire logic dev_sda_oe, // Target pulls data low.
    input wire logic write_busy, // Target write cycle.
    input wire logic standby     // Target idle.
);
    localparam int ACK_MAX = 4 * QUARTER + 8;
    logic scl_q, sda_q, scl_d, sda_d;
    logic [3:0] bits_q, bits_d;
    int busy_q, busy_d, stop_q, stop_d;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Counts clock rises since a start, wrapping to zero on every ninth, and cycles since a stop and within a write.
    always_comb begin
        scl_d = scl;
        sda_d = sda;
        bits_d = bits_q;
        if (scl && scl_q && sda_q && !sda) begin
            bits_d = 4'h0;
        end else if (scl && !scl_q) begin
            bits_d = (bits_q == 4'h8) ? 4'h0 : bits_q + 4'h1;
        end
        busy_d = write_busy ? busy_q + 1 : 0;
        stop_d = (scl && scl_q && !sda_q && sda) ? 0 : ((stop_q < 64) ? stop_q + 1 : stop_q);
    end

    // Registers the helper state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bits_q <= 4'h0;
            busy_q <= 0;
            stop_q <= 64;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            bits_q <= bits_d;
            busy_q <= busy_d;
            stop_q <= stop_d;
        end
    end

    chk_ack_clock_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("target data changed while clock high");
    chk_ack_ninth_bit: assert property ($rose(dev_sda_oe) |-> bits_q == 4'h8)
        else $error("acknowledge not after eighth bit");
    chk_ack_one_bit: assert property ($rose(dev_sda_oe) |-> ##[1:ACK_MAX] !dev_sda_oe)
        else $error("acknowledge held too long");
    chk_busy_silent: assert property (write_busy |-> !dev_sda_oe)
        else $error("target drove data during write cycle");
    chk_busy_after_stop: assert property ($rose(write_busy) |-> stop_q < 16)
        else $error("write cycle began without a stop");
    chk_write_time: assert property ($fell(write_busy) |-> busy_q == WRITE_CYCLES)
        else $error("write cycle length wrong");
    chk_write_bound: assert property (busy_q <= WRITE_CYCLES)
        else $error("write cycle too long");
    chk_standby_busy: assert property (write_busy |-> !standby)
        else $error("standby during write cycle");
    chk_standby_after: assert property ($fell(write_busy) |-> ##[0:4] standby)
        else $error("no standby after write cycle");
    chk_standby_quiet: assert property (standby |-> !dev_sda_oe)
        else $error("target drove data in standby");
endmodule
`default_nettype wire

// >>> tb/test_serial_eeprom_target_write_path.sv
// Bench: bus controller and memory target joined over the link, with a byte model.
`timescale 1ns/1ps
`default_nettype none
`include "serial_mem_consts.svh"
module test_serial_eeprom_target_write_path
    import serial_mem_pkg::*;
;
    localparam int Q = 10;
    localparam int WC = 1000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] av_addr = 4'h0;
    logic av_read = 1'b0;
    logic av_write = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata, st;
    logic av_wait, write_busy, standby, ack;
    logic [2:0] sel = 3'h0;
    logic [8:0] peek_addr = 9'h000;
    logic [7:0] peek_data, devw, a, d;
    logic [7:0] model [256];
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    serial_link_if link();
    bus_controller #(.QUARTER(Q)) bus_controller_inst (
        .clk(clk), .nrst(nrst), .link(link), .avs_address(av_addr), .avs_read(av_read),
        .avs_write(av_write), .avs_writedata(av_wdata), .avs_readdata(av_rdata),
        .avs_waitrequest(av_wait));
    eeprom_target #(.VARIANT_4K(1'b0), .WRITE_CYCLES(WC)) eeprom_target_inst (
        .clk(clk), .nrst(nrst), .link(link), .chip_select_pin_upper(sel[2]),
        .chip_select_pin_middle(sel[1]), .chip_select_pin_lowest(sel[0]),
        .peek_addr(peek_addr), .peek_data(peek_data), .write_busy(write_busy),
        .standby(standby));
    serial_link_checker #(.QUARTER(Q), .WRITE_CYCLES(WC)) serial_link_checker_inst (
        .clk(clk), .nrst(nrst), .scl(link.scl), .sda(link.sda),
        .dev_sda_oe(link.dev_sda_oe), .write_busy(write_busy), .standby(standby));

    always #5 clk = ~clk;

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low at a rising edge.
    task automatic av_xfer(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        @(posedge clk);
        av_addr <= ad;
        av_write <= wr;
        av_read <= ~wr;
        av_wdata <= wd;
        @(posedge clk);
        while (av_wait !== 1'b0) @(posedge clk);
        st = av_rdata;
        av_write <= 1'b0;
        av_read <= 1'b0;
    endtask

    // Issues one link command and waits for the engine to go idle.
    task automatic send(input host_op_t op, input logic [7:0] b);
        av_xfer(1'b1, `CMD_OFFSET, {22'h0, op, b});
        st = 32'h1;
        while (st[`STAT_BUSY_BIT] !== 1'b0) av_xfer(1'b0, `STATUS_OFFSET, 32'h0);
        ack = st[`STAT_ACK_BIT];
    endtask

    task automatic address(input logic [7:0] w);
        send(OP_START, 8'h00);
        send(OP_BYTE, w);
    endtask

    task automatic check_mem(input logic [7:0] ad);
        @(posedge clk);
        peek_addr <= {1'b0, ad};
        @(posedge clk);
        @(negedge clk);
        check_word("array word", {24'h0, model[ad]}, {24'h0, peek_data});
    endtask

    // Main sequence: reset, refusals, byte write with polling, wrapping page write.
    initial begin
        void'($urandom(38));
        @(posedge clk);
        sel <= 3'($urandom);
        repeat (19) @(posedge clk);
        check_bit("standby in reset", 1'b1, standby);
        check_bit("data wire idle", 1'b1, link.sda);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        devw = {4'hA, sel, 1'b0};
        av_xfer(1'b0, 4'h8, 32'h0);
        check_word("unmapped read", 32'h0, st);
        send(OP_RECOVER, 8'h00);
        check_bit("recovery", 1'b1, st[`STAT_BUS_OK_BIT]);
        for (int k = 0; k < 4; k++) begin
            address((k == 3) ? {4'hB, sel, 1'b0} : {4'hA, sel ^ 3'(1 << k), 1'b0});
            check_bit("mismatch ack", 1'b0, ack);
            check_bit("mismatch standby", 1'b1, standby);
            send(OP_STOP, 8'h00);
        end
        address({4'hA, sel, 1'b1});
        check_bit("read address ack", 1'b1, ack);
        send(OP_STOP, 8'h00);
        check_bit("standby after read", 1'b1, standby);
        a = 8'($urandom);
        d = 8'($urandom);
        address(devw);
        check_bit("address ack", 1'b1, ack);
        address(devw);
        check_bit("restart ack", 1'b1, ack);
        send(OP_BYTE, a);
        check_bit("word address ack", 1'b1, ack);
        send(OP_BYTE, d);
        check_bit("data ack", 1'b1, ack);
        model[a] = d;
        send(OP_STOP, 8'h00);
        check_bit("write busy", 1'b1, write_busy);
        address(devw);
        check_bit("poll while busy", 1'b0, ack);
        send(OP_STOP, 8'h00);
        while (write_busy !== 1'b0) @(posedge clk);
        check_bit("standby after write", 1'b1, standby);
        check_mem(a);
        address(devw);
        check_bit("poll after write", 1'b1, ack);
        send(OP_STOP, 8'h00);
        check_bit("no write without data", 1'b0, write_busy);
        a = 8'($urandom);
        address(devw);
        send(OP_BYTE, a);
        for (int i = 0; i < 10; i++) begin
            d = 8'($urandom);
            send(OP_BYTE, d);
            check_bit("page data ack", 1'b1, ack);
            model[{a[7:3], 3'(a[2:0] + i)}] = d;
        end
        send(OP_STOP, 8'h00);
        while (write_busy !== 1'b0) @(posedge clk);
        for (int i = 0; i < 8; i++) check_mem({a[7:3], 3'(i)});
        tally_and_finish();
    end
endmodule
`default_nettype wire
